/* hw/pgl_top.sv */
// module: shadow to active global load, one-shot arming and cross-module link
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - writes land in shadow, active loads on events
// - global enable loads opted registers on chosen event
// - per-register select opts into global loading
// - transfer after configured number of strobes
// - control bit selects one-shot load mode
// - arm bit loads on next selected event
// - after one-shot load, block until rearmed
// - linked period/compare writes update all linked modules
// - arm and force commands linkable across modules
// - single load strobe for coherent multi-module update
// - phase fine step no coarser than 150 ps
module pgl_top #(
    parameter int MOD_ID = 0
) (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // register bus
    input wire pgl_pkg::pgl_apb_req_type apb_req,
    output pgl_pkg::pgl_apb_rsp_type apb_rsp,
    // pwm events, bit 0 is the local counter-zero point
    input wire logic [pgl_pkg::NEVT-1:0] evt_in,
    // cross-module link
    input wire pgl_pkg::pgl_link_type link_in,
    output pgl_pkg::pgl_link_type link_out,
    // active parameters
    output logic [pgl_pkg::NREG-1:0][pgl_pkg::DW-1:0] active_out,
    output logic [pgl_pkg::FINE_W-1:0] phase_fine,
    output logic gld_strobe
);
    import pgl_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic in_bank(input logic [AW-1:0] a, input logic [AW-1:0] base);
        in_bank = (a >= base) && (a < base + AW'(4 * NREG)) && (a[1:0] == 2'b00);
    endfunction

    function automatic logic [IDW-1:0] bank_idx(input logic [AW-1:0] a,
                                                input logic [AW-1:0] base);
        logic [AW-1:0] d;
        d = a - base;
        bank_idx = d[IDW+1:2];
    endfunction

    // clipping keeps the fine field inside one clock period of steps
    function automatic logic [DW-1:0] fit_phase(input logic [DW-1:0] v);
        logic [DW-1:0] r;
        r = v;
        if (v[FINE_LSB+:FINE_W] > FINE_W'(FINE_STEPS - 1)) begin
            r[FINE_LSB+:FINE_W] = FINE_W'(FINE_STEPS - 1);
        end
        fit_phase = r;
    endfunction

    function automatic logic addr_ok(input logic [AW-1:0] a);
        addr_ok = (a == OFS_CTRL) || (a == OFS_CMD) || (a == OFS_SEL) || (a == OFS_LINK)
            || (a == OFS_STATUS) || in_bank(a, OFS_SHADOW) || in_bank(a, OFS_ACTIVE);
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] ctrl_ff, nxt_ctrl;
    logic [NREG-1:0] sel_ff, nxt_sel;
    logic [2*NMOD-1:0] link_ff, nxt_link;
    logic [NREG-1:0][DW-1:0] shadow_ff, nxt_shadow;
    logic [NREG-1:0][DW-1:0] active_ff, nxt_active;
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic armed_ff, nxt_armed;
    logic strobe_ff, nxt_strobe;
    logic [DW-1:0] rdata_ff, nxt_rdata;

    logic wr_en, rd_setup, gld_en, osht_mode, sel_evt, gld_evt, cnt_hit, allow;
    logic own_arm, own_force, lnk_reg, lnk_cmd, arm_req, force_req, transfer;
    logic own_shw, lnk_ok;
    logic [IDW-1:0] own_idx;
    logic [CNT_W-1:0] thresh, cnt_inc;
    logic [EVSEL_W-1:0] evsel;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    assign wr_en = ce && apb_req.psel && apb_req.penable && apb_req.pwrite
        && addr_ok(apb_req.paddr);
    assign rd_setup = ce && apb_req.psel && !apb_req.penable;
    assign own_shw = wr_en && in_bank(apb_req.paddr, OFS_SHADOW);
    assign own_idx = bank_idx(apb_req.paddr, OFS_SHADOW);
    assign own_arm = wr_en && (apb_req.paddr == OFS_CMD) && apb_req.pwdata[CMD_ARM_BIT];
    assign own_force = wr_en && (apb_req.paddr == OFS_CMD) && apb_req.pwdata[CMD_FORCE_BIT];
    // answer in the access cycle; a frozen block stretches the access
    assign apb_rsp.pready = ce;
    assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !addr_ok(apb_req.paddr);
    assign apb_rsp.prdata = rdata_ff;

    // ------------------------------------------------------------
    // link
    // ------------------------------------------------------------
    // broadcast period/compare writes
    // combinational so every linked module stores on the same edge as this one
    always_comb begin
        link_out = '0;
        link_out.src = IDW'(MOD_ID);
        link_out.idx = own_idx;
        link_out.data = apb_req.pwdata;
        link_out.valid = own_shw && ((own_idx == IDW'(IDX_PERIOD))
            || (own_idx == IDW'(IDX_COMPARE)));
        link_out.arm = own_arm;
        link_out.force_ld = own_force;
    end

    assign lnk_ok = link_in.src != IDW'(MOD_ID);
    assign lnk_reg = lnk_ok && link_in.valid && link_ff[link_in.src]
        && ((link_in.idx == IDW'(IDX_PERIOD)) || (link_in.idx == IDW'(IDX_COMPARE)));
    assign lnk_cmd = lnk_ok && link_ff[LINK_CMD_LSB + int'(link_in.src)];
    // linked arm and force act like local ones
    assign arm_req = own_arm || (ce && lnk_cmd && link_in.arm);
    assign force_req = own_force || (ce && lnk_cmd && link_in.force_ld);

    // ------------------------------------------------------------
    // global load event path
    // ------------------------------------------------------------
    assign gld_en = ctrl_ff[CTL_EN_BIT];
    assign osht_mode = ctrl_ff[CTL_OSHT_BIT];
    assign evsel = ctrl_ff[CTL_EVSEL_LSB+:EVSEL_W];
    assign sel_evt = evt_in[evsel];
    // one chosen event drives all opted registers
    assign gld_evt = ce && gld_en && sel_evt;
    // a count of zero is taken as one strobe
    assign thresh = (ctrl_ff[CTL_CNT_LSB+:CNT_W] == '0) ? CNT_W'(1)
        : ctrl_ff[CTL_CNT_LSB+:CNT_W];
    assign cnt_inc = cnt_ff + CNT_W'(1);
    // transfer only on the configured strobe
    assign cnt_hit = gld_evt && (cnt_inc >= thresh);
    // one-shot mode gates the transfer on the arm
    assign allow = !osht_mode || armed_ff;
    // disarmed one-shot blocks global events; force still loads
    assign transfer = (cnt_hit && allow) || (ce && gld_en && force_req);

    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_armed = armed_ff;
        nxt_strobe = strobe_ff;
        if (ce) begin
            nxt_strobe = transfer;
            // restart count after the threshold strobe
            if (cnt_hit) begin
                nxt_cnt = '0;
            end else if (gld_evt) begin
                nxt_cnt = cnt_inc;
            end
            // arm spent by the transfer; a new arm wins
            if (arm_req) begin
                nxt_armed = 1'b1;
            end else if (transfer && osht_mode) begin
                nxt_armed = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // registers, shadow and active
    // ------------------------------------------------------------
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_sel = sel_ff;
        nxt_link = link_ff;
        nxt_shadow = shadow_ff;
        nxt_active = active_ff;
        nxt_rdata = rdata_ff;
        if (ce) begin
            if (wr_en && apb_req.paddr == OFS_CTRL) begin
                nxt_ctrl = apb_req.pwdata[7:0];
            end
            if (wr_en && apb_req.paddr == OFS_SEL) begin
                nxt_sel = apb_req.pwdata[NREG-1:0];
            end
            if (wr_en && apb_req.paddr == OFS_LINK) begin
                nxt_link = apb_req.pwdata[2*NMOD-1:0];
            end
            // linked write, own write of the same cycle wins
            if (lnk_reg) begin
                nxt_shadow[link_in.idx] = link_in.data;
            end
            // software only reaches the shadow copy
            if (own_shw) begin
                nxt_shadow[own_idx] = apb_req.pwdata;
            end
            // fine field clipped to one clock period of 150 ps steps
            nxt_shadow[IDX_PHASE] = fit_phase(nxt_shadow[IDX_PHASE]);
            for (int i = 0; i < NREG; i++) begin
                // global registers ignore their own load point
                if (gld_en && sel_ff[i]) begin
                    // one strobe loads every opted register
                    if (transfer) begin
                        nxt_active[i] = shadow_ff[i];
                    end
                end else if (evt_in[LOCAL_EVT]) begin
                    nxt_active[i] = shadow_ff[i];
                end
            end
            if (rd_setup) begin
                nxt_rdata = '0;
                if (apb_req.paddr == OFS_CTRL) begin
                    nxt_rdata[7:0] = ctrl_ff;
                end else if (apb_req.paddr == OFS_CMD) begin
                    nxt_rdata[CMD_ARM_BIT] = armed_ff;
                end else if (apb_req.paddr == OFS_SEL) begin
                    nxt_rdata[NREG-1:0] = sel_ff;
                end else if (apb_req.paddr == OFS_LINK) begin
                    nxt_rdata[2*NMOD-1:0] = link_ff;
                end else if (apb_req.paddr == OFS_STATUS) begin
                    nxt_rdata[0] = armed_ff;
                    nxt_rdata[STS_CNT_LSB+:CNT_W] = cnt_ff;
                end else if (in_bank(apb_req.paddr, OFS_SHADOW)) begin
                    nxt_rdata = shadow_ff[bank_idx(apb_req.paddr, OFS_SHADOW)];
                end else if (in_bank(apb_req.paddr, OFS_ACTIVE)) begin
                    nxt_rdata = active_ff[bank_idx(apb_req.paddr, OFS_ACTIVE)];
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= 8'h00;
            sel_ff <= '0;
            link_ff <= '0;
            shadow_ff <= {NREG{RST_VAL}};
            active_ff <= {NREG{RST_VAL}};
            cnt_ff <= '0;
            armed_ff <= 1'b0;
            strobe_ff <= 1'b0;
            rdata_ff <= RST_VAL;
        end else begin
            ctrl_ff <= nxt_ctrl;
            sel_ff <= nxt_sel;
            link_ff <= nxt_link;
            shadow_ff <= nxt_shadow;
            active_ff <= nxt_active;
            cnt_ff <= nxt_cnt;
            armed_ff <= nxt_armed;
            strobe_ff <= nxt_strobe;
            rdata_ff <= nxt_rdata;
        end
    end

    assign active_out = active_ff;
    assign phase_fine = active_ff[IDX_PHASE][FINE_LSB+:FINE_W];
    assign gld_strobe = strobe_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence arm_seq;
        arm_req ##1 armed_ff;
    endsequence
    sequence shot_seq;
        osht_mode && armed_ff && cnt_hit && !arm_req;
    endsequence

    shadow_hold_a: assert property ((ce && !evt_in[LOCAL_EVT] && !transfer) |=>
        active_ff == $past(active_ff)) else $error("active changed with no load");
    opt_load_a: assert property ((gld_en && sel_ff[IDX_COMPARE] && transfer) |=>
        active_ff[IDX_COMPARE] == $past(shadow_ff[IDX_COMPARE]))
        else $error("opted register not loaded");
    opt_ignore_a: assert property ((ce && gld_en && sel_ff[IDX_COMPARE]
        && !transfer) |=> $stable(active_ff[IDX_COMPARE]))
        else $error("opted register loaded on own event");
    cnt_gate_a: assert property ((gld_evt && (cnt_inc < thresh) && !force_req) |=>
        !gld_strobe && (cnt_ff == $past(cnt_inc))) else $error("transfer before strobe count");
    cnt_restart_a: assert property (cnt_hit |=> cnt_ff == '0)
        else $error("strobe counter not restarted");
    arm_block_a: assert property ((osht_mode && !armed_ff && !force_req) |->
        !transfer) else $error("one-shot load without arm");
    arm_take_a: assert property (arm_seq ##0 (!cnt_hit && !force_req) |=> armed_ff)
        else $error("arm lost before its event");
    arm_fire_a: assert property ((osht_mode && armed_ff && cnt_hit) |=> gld_strobe)
        else $error("armed event did not load");
    force_load_a: assert property ((ce && gld_en && force_req) |=> gld_strobe)
        else $error("forced load missing");
    shot_spent_a: assert property (shot_seq |=> !armed_ff [*2] or
        (!armed_ff ##1 armed_ff)) else $error("arm not spent after load");
    link_out_a: assert property ((own_shw && own_idx == IDW'(IDX_PERIOD)) |->
        link_out.valid && link_out.data == apb_req.pwdata) else $error("period not sent");
    link_cmd_a: assert property ((ce && lnk_cmd && link_in.arm) |=>
        armed_ff) else $error("linked arm ignored");
    strobe_out_a: assert property (transfer |=> gld_strobe ##1 !gld_strobe or
        gld_strobe) else $error("load strobe missing");
    fine_step_a: assert property (phase_fine <= FINE_W'(FINE_STEPS - 1))
        else $error("fine phase beyond one clock");
endmodule
`default_nettype wire

/* shared/pgl_pkg.sv */
// package: register map, fields and carrier types of the global load block
package pgl_pkg;
    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int DW = 32;
    localparam int AW = 8;
    localparam int NREG = 5;
    localparam int NMOD = 8;
    localparam int IDW = 3;
    localparam int NEVT = 8;
    // ------------------------------------------------------------
    // byte offsets
    // ------------------------------------------------------------
    localparam logic [AW-1:0] OFS_CTRL = 8'h00;
    localparam logic [AW-1:0] OFS_CMD = 8'h04;
    localparam logic [AW-1:0] OFS_SEL = 8'h08;
    localparam logic [AW-1:0] OFS_LINK = 8'h0c;
    localparam logic [AW-1:0] OFS_SHADOW = 8'h10;
    localparam logic [AW-1:0] OFS_STATUS = 8'h24;
    localparam logic [AW-1:0] OFS_ACTIVE = 8'h30;
    // ------------------------------------------------------------
    // fields
    // ------------------------------------------------------------
    localparam int CTL_EN_BIT = 0;
    localparam int CTL_EVSEL_LSB = 1;
    localparam int EVSEL_W = 3;
    localparam int CTL_CNT_LSB = 4;
    localparam int CNT_W = 3;
    localparam int CTL_OSHT_BIT = 7;
    localparam int CMD_ARM_BIT = 0;
    localparam int CMD_FORCE_BIT = 1;
    localparam int LINK_CMD_LSB = 8;
    localparam int STS_CNT_LSB = 1;
    localparam int IDX_PERIOD = 0;
    localparam int IDX_COMPARE = 1;
    localparam int IDX_PHASE = 4;
    localparam int LOCAL_EVT = 0;
    localparam logic [DW-1:0] RST_VAL = 32'h0000_0000;
    // ------------------------------------------------------------
    // fine phase step
    // ------------------------------------------------------------
    localparam int FINE_LSB = 16;
    localparam int FINE_W = 9;
    localparam int FINE_STEP_PS = 150;
    localparam int CLK_PERIOD_PS = 50000;
    localparam int FINE_STEPS = (CLK_PERIOD_PS + FINE_STEP_PS - 1) / FINE_STEP_PS;
    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [AW-1:0] paddr;
        logic [DW-1:0] pwdata;
    } pgl_apb_req_type;
    typedef struct packed {
        logic [DW-1:0] prdata;
        logic pready;
        logic pslverr;
    } pgl_apb_rsp_type;
    typedef struct packed {
        logic valid;
        logic [IDW-1:0] src;
        logic [IDW-1:0] idx;
        logic [DW-1:0] data;
        logic arm;
        logic force_ld;
    } pgl_link_type;
endpackage

/* tb/tb_top.sv */
// testbench: apb driven checks of shadow, global, one-shot and link loading
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin \
    checked++; \
    if ((gt) !== (ex)) begin \
        err_count++; \
        $display("CHECK FAILED %s exp=%0h got=%0h", nm, ex, gt); \
    end \
end
module tb_top;
    import pgl_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    pgl_apb_req_type apb_req = '0;
    pgl_apb_rsp_type apb_rsp;
    logic [NEVT-1:0] evt_in = '0;
    pgl_link_type link_in = '0;
    pgl_link_type link_out;
    pgl_link_type lo;
    logic [NREG-1:0][DW-1:0] active_out;
    logic [FINE_W-1:0] phase_fine;
    logic gld_strobe;
    logic gs;
    logic last_err;
    logic [DW-1:0] rdata;
    int err_count = 0;
    int checked = 0;
    always #25 pclk = ~pclk;
    pgl_top #(.MOD_ID(0)) dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .evt_in(evt_in), .link_in(link_in), .link_out(link_out),
        .active_out(active_out), .phase_fine(phase_fine), .gld_strobe(gld_strobe));
    // ------------------------------------------------------------
    // bus and event tasks
    // ------------------------------------------------------------
    // request held until pready is sampled high; link_out looked at inside the access cycle
    task automatic xfer(input logic wr, input logic [AW-1:0] a, input logic [DW-1:0] d);
        @(posedge pclk);
        apb_req.psel <= 1'b1;
        apb_req.penable <= 1'b0;
        apb_req.pwrite <= wr;
        apb_req.paddr <= a;
        apb_req.pwdata <= d;
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        #1;
        lo = link_out;
        last_err = apb_rsp.pslverr;
        do begin
            @(posedge pclk);
        end while (apb_rsp.pready !== 1'b1);
        rdata = apb_rsp.prdata;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] ex, input string nm);
        xfer(1'b0, a, '0);
        `CHK(nm, ex, rdata)
    endtask
    // one-cycle event pulse; returns just after the edge that sampled it
    task automatic pulse(input int idx);
        @(posedge pclk);
        evt_in <= NEVT'(1) << idx;
        @(posedge pclk);
        evt_in <= '0;
        #1;
        gs = gld_strobe;
    endtask
    task automatic link(input logic [IDW-1:0] s, input logic [IDW-1:0] i, input logic [DW-1:0] d,
                        input logic arm);
        @(posedge pclk);
        link_in <= '{valid: ~arm, src: s, idx: i, data: d, arm: arm, force_ld: 1'b0};
        @(posedge pclk);
        link_in <= '0;
    endtask
    function automatic logic [DW-1:0] ctl(input logic en, input int ev, input int cnt,
                                          input logic os);
        return DW'(en) | (DW'(ev) << CTL_EVSEL_LSB) | (DW'(cnt) << CTL_CNT_LSB)
            | (DW'(os) << CTL_OSHT_BIT);
    endfunction
    // ------------------------------------------------------------
    // end of run
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // generous: the whole sequence needs well under 1000 cycles
    initial begin
        #(50 * 5000);
        err_count++;
        stop_test();
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        logic [DW-1:0] prev;
        logic [DW-1:0] exp_cmp;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        wr(8'h80, 32'h0000_0001);
        `CHK("unmapped err", 1'b1, last_err) // unmapped refused
        rd(OFS_CTRL, RST_VAL, "ctrl reset"); // global load off
        // shadow write leaves active alone until the local load point
        wr(OFS_SHADOW, 32'h0000_1234);
        `CHK("active0 early", 32'h0000_0000, active_out[IDX_PERIOD]) // no early load
        rd(OFS_SHADOW, 32'h0000_1234, "shadow0"); // shadow written
        pulse(LOCAL_EVT);
        `CHK("active0 local", 32'h0000_1234, active_out[IDX_PERIOD]) // load on event
        // opted compare register ignores the local point, loads on event 2
        wr(OFS_SEL, 32'h0000_0002);
        wr(OFS_CTRL, ctl(1'b1, 2, 1, 1'b0));
        wr(OFS_SHADOW + 8'h04, 32'h0000_00aa);
        pulse(LOCAL_EVT);
        `CHK("opted no local", 32'h0000_0000, active_out[IDX_COMPARE]) // opt-in
        pulse(2);
        `CHK("opted global", 32'h0000_00aa, active_out[IDX_COMPARE]) // chosen event
        `CHK("strobe", 1'b1, gs) // single strobe
        // count of three, twice in a row so the restart shows
        wr(OFS_CTRL, ctl(1'b1, 2, 3, 1'b0));
        prev = 32'h0000_00aa;
        for (int r = 0; r < 2; r++) begin
            wr(OFS_SHADOW + 8'h04, 32'h0000_00bb + DW'(r));
            for (int k = 1; k <= 3; k++) begin
                exp_cmp = (k == 3) ? 32'h0000_00bb + DW'(r) : prev;
                pulse(2);
                `CHK("count load", exp_cmp, active_out[IDX_COMPARE]) // restart
            end
            prev = 32'h0000_00bb + DW'(r);
        end
        // one-shot: no load unarmed, one load when armed, then blocked
        wr(OFS_CTRL, ctl(1'b1, 2, 1, 1'b1));
        wr(OFS_SHADOW + 8'h04, 32'h0000_00dd);
        pulse(2);
        `CHK("unarmed", prev, active_out[IDX_COMPARE]) // one-shot mode
        wr(OFS_CMD, 32'h0000_0001);
        `CHK("link out arm", 1'b1, lo.arm) // arm sent
        rd(OFS_STATUS, 32'h0000_0001, "armed"); // arm taken
        pulse(2);
        `CHK("armed load", 32'h0000_00dd, active_out[IDX_COMPARE]) // next event
        wr(OFS_SHADOW + 8'h04, 32'h0000_00ee);
        pulse(2);
        `CHK("blocked", 32'h0000_00dd, active_out[IDX_COMPARE]) // blocked until rearm
        rd(OFS_CMD, 32'h0000_0000, "disarmed"); // arm consumed
        // arm and shadow writes arriving from linked module 3
        wr(OFS_LINK, 32'h0000_0808);
        link(3'd3, 3'd0, 32'h0, 1'b1);
        pulse(2);
        `CHK("linked arm", 32'h0000_00ee, active_out[IDX_COMPARE]) // linked arm
        link(3'd3, 3'd0, 32'h0000_0055, 1'b0);
        rd(OFS_SHADOW, 32'h0000_0055, "linked write"); // linked write
        link(3'd5, 3'd0, 32'h0000_0066, 1'b0);
        rd(OFS_SHADOW, 32'h0000_0055, "unlinked src"); // unlinked ignored
        wr(OFS_SHADOW + 8'h04, 32'h0000_0077);
        `CHK("link out valid", 1'b1, lo.valid) // own write sent
        `CHK("link out data", 32'h0000_0077, lo.data) // same value sent
        `CHK("link out idx", 3'h1, lo.idx) // same register
        // fine phase field, including the clip at the top step
        wr(OFS_SHADOW + 8'h10, 32'h0064_0000);
        pulse(LOCAL_EVT);
        `CHK("phase fine", 9'h064, phase_fine) // fine step placed
        wr(OFS_SHADOW + 8'h10, 32'h01ff_0000);
        pulse(LOCAL_EVT);
        `CHK("phase clip", 9'h14d, phase_fine) // clipped top step
        // force loads at once, even with the one-shot disarmed
        wr(OFS_CMD, 32'h0000_0002);
        `CHK("link out force", 1'b1, lo.force_ld) // force sent
        rd(OFS_ACTIVE + 8'h04, 32'h0000_0077, "forced load"); // force loads
        // a frozen block holds the bus off
        @(posedge pclk);
        ce <= 1'b0;
        #1;
        `CHK("pready frozen", 1'b0, apb_rsp.pready) // bus held off
        @(posedge pclk);
        ce <= 1'b1;
        stop_test();
    end
endmodule
`default_nettype wire
